//--- core/nvc_ctrl.sv
// Data EEPROM access controller: address, data and control registers with array and page buffer.
`timescale 1ns/100ps
// What this block does
// - Address pair forms a 9-bit linear byte address over 512 bytes.
// - Upper seven bits of the address pair always read as zero.
// - Data register gives byte to program and receives byte read.
// - A read stalls the CPU for four clock cycles.
// - A program start stalls the CPU for two clock cycles.
// - Busy bit 7 is set from program start until the operation finishes.
// - Page mode bit stays set until program completes or buffer flushed.
// - Writes to the page mode bit are ignored while strobe is set.
// - Mode field picks erase-write, erase, write or flush timing and action.
// - Mode field writes are discarded while the program strobe is set.
// - Reset clears the mode field unless programming is in progress.
// - Ready interrupt held while enabled, global enable set, strobe clear.
// - Ready interrupt suppressed during programming or flash self-store.
// - Block times each program operation and reports completion in status.
// - All access registers sit in the CPU I/O register space.
// - Arm bit self-clears after four cycles; strobe acts only while armed.
// - Strobe bit clears itself when the programming time has elapsed.
// - Read strobe returns the addressed byte into the data register at once.
// - In page mode each data write while strobe is clear loads the page buffer at low address.
module nvc_ctrl #(
  parameter int unsigned CYC_ERASE_WR = 32'(nvc_pkg::NVC_CYC_ERASE_WR),
  parameter int unsigned CYC_SINGLE   = 32'(nvc_pkg::NVC_CYC_SINGLE)
) (
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  input  wire nvc_pkg::nvc_io_req_s io_req,
  output logic [7:0]              io_rdata,
  output logic                    cpu_halt,
  input  wire logic               global_irq_enable,
  input  wire logic               flash_self_store,
  output logic                    ready_irq
);

  localparam int AW = nvc_pkg::NVC_ADDR_W;
  localparam int PW = nvc_pkg::NVC_PAGE_AW;
  localparam int CW = nvc_pkg::NVC_CNT_W;

  logic [AW-1:0] nvm_address_q;
  logic [7:0]    nvm_data_q;
  logic          page_mode_enable_q;
  logic [1:0]    prog_mode_field_q;
  logic          ready_irq_enable_q;
  logic          write_arm_q;
  logic [2:0]    arm_cnt_q;
  logic          program_strobe_q;
  logic [CW-1:0] prog_cnt_q;
  logic [2:0]    stall_cnt_q;
  logic [7:0]    array_mem [nvc_pkg::NVC_DEPTH];
  logic [7:0]    page_buf_q [nvc_pkg::NVC_PAGE_SIZE];
  logic [nvc_pkg::NVC_PAGE_SIZE-1:0] page_used_q;
  logic [AW-1:0] prog_addr_q;
  logic [1:0]    prog_op_q;
  logic          prog_page_q;
  logic [7:0]    prog_byte_q;

  // Decoded accesses.
  logic wr_ctl;
  logic wr_dat;
  logic wr_alo;
  logic wr_ahi;
  logic strobe_go;
  logic read_go;
  logic prog_done;
  logic [7:0] w;

  assign w      = io_req.wdata;
  assign wr_ctl = io_req.wr && (io_req.addr == nvc_pkg::NVC_OFS_CONTROL);
  assign wr_dat = io_req.wr && (io_req.addr == nvc_pkg::NVC_OFS_DATA);
  // The address may not move while programming, so address writes are dropped then.
  assign wr_alo = io_req.wr && (io_req.addr == nvc_pkg::NVC_OFS_ADDR_LOW) && !program_strobe_q;
  assign wr_ahi = io_req.wr && (io_req.addr == nvc_pkg::NVC_OFS_ADDR_HIGH) && !program_strobe_q;
  assign strobe_go = wr_ctl && w[nvc_pkg::NVC_BIT_STROBE] && write_arm_q && !program_strobe_q
                     && !flash_self_store;
  assign read_go   = wr_ctl && w[nvc_pkg::NVC_BIT_READ] && !program_strobe_q
                     && !w[nvc_pkg::NVC_BIT_STROBE];
  assign prog_done = program_strobe_q && (prog_cnt_q == '0);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      nvm_address_q <= '0;
    end else if (wr_alo) begin
      nvm_address_q[7:0] <= w;
    end else if (wr_ahi) begin
      nvm_address_q[8] <= w[0];
    end
  end

  // data register, also loaded by reads.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      nvm_data_q <= nvc_pkg::NVC_DATA_RST;
    end else if (read_go) begin
      nvm_data_q <= array_mem[nvm_address_q];
    end else if (wr_dat) begin
      nvm_data_q <= w;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      write_arm_q <= 1'b0;
      arm_cnt_q   <= '0;
    end else if (wr_ctl && w[nvc_pkg::NVC_BIT_ARM]) begin
      write_arm_q <= 1'b1;
      arm_cnt_q   <= 3'(nvc_pkg::NVC_ARM_CYCLES - 1);
    end else if (write_arm_q) begin
      if (arm_cnt_q == '0) begin
        write_arm_q <= 1'b0;
      end else begin
        arm_cnt_q <= arm_cnt_q - 3'h1;
      end
    end
  end

  // Ready interrupt enable is a plain control bit.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ready_irq_enable_q <= 1'b0;
    end else if (wr_ctl) begin
      ready_irq_enable_q <= w[nvc_pkg::NVC_BIT_RIE];
    end
  end

  // Mode field keeps its value across reset while an operation runs.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      if (!program_strobe_q) begin
        prog_mode_field_q <= nvc_pkg::NVC_PM_RST;
      end
    end else if (wr_ctl && !program_strobe_q) begin
      prog_mode_field_q <= w[nvc_pkg::NVC_BIT_PM_HI:nvc_pkg::NVC_BIT_PM_LO];
    end
  end

  // Page mode bit: set by software, cleared by completion or flush.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      page_mode_enable_q <= 1'b0;
    end else if (prog_done && prog_page_q) begin
      page_mode_enable_q <= 1'b0;
    end else if (wr_ctl && !program_strobe_q && w[nvc_pkg::NVC_BIT_PAGE]) begin
      page_mode_enable_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      program_strobe_q <= 1'b0;
      prog_cnt_q       <= '0;
      prog_op_q        <= '0;
      prog_page_q      <= 1'b0;
      prog_addr_q      <= '0;
      prog_byte_q      <= '0;
    end else if (strobe_go) begin
      program_strobe_q <= 1'b1;
      prog_op_q        <= prog_mode_field_q;
      prog_page_q      <= page_mode_enable_q;
      prog_addr_q      <= nvm_address_q;
      prog_byte_q      <= nvm_data_q;
      case (nvc_pkg::nvc_pm_e'(prog_mode_field_q))
        nvc_pkg::NVC_PM_ERASE_WRITE: prog_cnt_q <= CW'(CYC_ERASE_WR - 1);
        nvc_pkg::NVC_PM_ERASE_ONLY:  prog_cnt_q <= CW'(CYC_SINGLE - 1);
        nvc_pkg::NVC_PM_WRITE_ONLY:  prog_cnt_q <= CW'(CYC_SINGLE - 1);
        default:                     prog_cnt_q <= '0;
      endcase
    end else if (program_strobe_q) begin
      if (prog_done) begin
        program_strobe_q <= 1'b0;
      end else begin
        prog_cnt_q <= prog_cnt_q - CW'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || (prog_done && prog_page_q)) begin
      page_used_q <= '0;
    end else if (wr_dat && page_mode_enable_q && !program_strobe_q) begin
      page_used_q[nvm_address_q[PW-1:0]] <= 1'b1;
    end
  end

  // Repeated loads of one byte AND together, as the buffer cells only clear bits.
  for (genvar i = 0; i < nvc_pkg::NVC_PAGE_SIZE; i++) begin : g_page
    always_ff @(posedge core_clk) begin
      if (sys_rst || (prog_done && prog_page_q)) begin
        page_buf_q[i] <= 8'hff;
      end else if (wr_dat && page_mode_enable_q && !program_strobe_q
                   && (nvm_address_q[PW-1:0] == PW'(i))) begin
        page_buf_q[i] <= page_buf_q[i] & w;
      end
    end
  end

  // Array update at the end of an operation; no reset, it models nonvolatile cells.
  always_ff @(posedge core_clk) begin
    if (!sys_rst && prog_done && (prog_op_q != nvc_pkg::NVC_PM_FLUSH)) begin
      for (int j = 0; j < nvc_pkg::NVC_PAGE_SIZE; j++) begin
        if (!prog_page_q ? (prog_addr_q[PW-1:0] == PW'(j)) : page_used_q[j]) begin
          case (nvc_pkg::nvc_pm_e'(prog_op_q))
            nvc_pkg::NVC_PM_ERASE_ONLY: begin
              array_mem[{prog_addr_q[AW-1:PW], PW'(j)}] <= 8'hff;
            end
            nvc_pkg::NVC_PM_WRITE_ONLY: begin
              array_mem[{prog_addr_q[AW-1:PW], PW'(j)}] <=
                array_mem[{prog_addr_q[AW-1:PW], PW'(j)}]
                & (prog_page_q ? page_buf_q[j] : prog_byte_q);
            end
            default: begin
              array_mem[{prog_addr_q[AW-1:PW], PW'(j)}] <=
                prog_page_q ? page_buf_q[j] : prog_byte_q;
            end
          endcase
        end
      end
    end
  end

  // CPU halt: four cycles on read, two on program start, three on a page load.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stall_cnt_q <= '0;
    end else if (read_go) begin
      stall_cnt_q <= nvc_pkg::NVC_STALL_READ;
    end else if (strobe_go) begin
      stall_cnt_q <= nvc_pkg::NVC_STALL_PROG;
    end else if (wr_dat && page_mode_enable_q && !program_strobe_q) begin
      stall_cnt_q <= nvc_pkg::NVC_STALL_LOAD;
    end else if (stall_cnt_q != '0) begin
      stall_cnt_q <= stall_cnt_q - 3'h1;
    end
  end
  assign cpu_halt = (stall_cnt_q != '0);

  always_comb begin
    io_rdata = 8'h00;
    if (io_req.rd) begin
      case (io_req.addr)
        nvc_pkg::NVC_OFS_CONTROL: begin
          io_rdata = {program_strobe_q, page_mode_enable_q, prog_mode_field_q,
                      ready_irq_enable_q, write_arm_q, program_strobe_q, 1'b0};
        end
        nvc_pkg::NVC_OFS_DATA:      io_rdata = nvm_data_q;
        nvc_pkg::NVC_OFS_ADDR_LOW:  io_rdata = nvm_address_q[7:0];
        nvc_pkg::NVC_OFS_ADDR_HIGH: io_rdata = {7'h00, nvm_address_q[8]};
        default:                    io_rdata = 8'h00;
      endcase
    end
  end

  assign ready_irq = ready_irq_enable_q && global_irq_enable && !program_strobe_q
                     && !flash_self_store;

endmodule

//--- common/nvc_pkg.sv
// Package with register offsets, control fields and timing counts of the data EEPROM access block.
package nvc_pkg;

  // I/O offsets of the four access registers.
  localparam logic [5:0] NVC_OFS_CONTROL   = 6'h00;
  localparam logic [5:0] NVC_OFS_DATA      = 6'h01;
  localparam logic [5:0] NVC_OFS_ADDR_LOW  = 6'h02;
  localparam logic [5:0] NVC_OFS_ADDR_HIGH = 6'h03;

  // Control register field positions.
  localparam int NVC_BIT_BUSY   = 7;
  localparam int NVC_BIT_PAGE   = 6;
  localparam int NVC_BIT_PM_HI  = 5;
  localparam int NVC_BIT_PM_LO  = 4;
  localparam int NVC_BIT_RIE    = 3;
  localparam int NVC_BIT_ARM    = 2;
  localparam int NVC_BIT_STROBE = 1;
  localparam int NVC_BIT_READ   = 0;

  // Geometry of the array and the page buffer.
  localparam int NVC_ADDR_W    = 9;
  localparam int NVC_DEPTH     = 512;
  localparam int NVC_PAGE_SIZE = 4;
  localparam int NVC_PAGE_AW   = 2;

  // Reset values.
  localparam logic [7:0] NVC_DATA_RST = 8'h00;
  localparam logic [1:0] NVC_PM_RST   = 2'h0;

  // Programming modes.
  typedef enum logic [1:0] {
    NVC_PM_ERASE_WRITE = 2'b00,
    NVC_PM_ERASE_ONLY  = 2'b01,
    NVC_PM_WRITE_ONLY  = 2'b10,
    NVC_PM_FLUSH       = 2'b11
  } nvc_pm_e;

  // Timing: clock rate and documented times.
  localparam longint NVC_CLK_HZ       = 20000000;
  localparam longint NVC_T_ERASE_WR_US = 3400;
  localparam longint NVC_T_SINGLE_US   = 1800;
  localparam longint NVC_CYC_ERASE_WR = (NVC_T_ERASE_WR_US * NVC_CLK_HZ + 999999) / 1000000;
  localparam longint NVC_CYC_SINGLE   = (NVC_T_SINGLE_US * NVC_CLK_HZ + 999999) / 1000000;
  localparam int     NVC_ARM_CYCLES   = 4;
  localparam logic [2:0] NVC_STALL_READ  = 3'h4;
  localparam logic [2:0] NVC_STALL_PROG  = 3'h2;
  localparam logic [2:0] NVC_STALL_LOAD  = 3'h3;
  localparam int     NVC_CNT_W        = 20;

  // One CPU access to the I/O space.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } nvc_io_req_s;

endpackage

//--- verification/nvc_ctrl_monitor.sv
// Checker of port timing and read values of the EEPROM access controller.
`timescale 1ns/100ps
module nvc_ctrl_monitor (
  input wire logic                 core_clk,
  input wire logic                 sys_rst,
  input wire nvc_pkg::nvc_io_req_s io_req,
  input wire logic [7:0]           io_rdata,
  input wire logic                 cpu_halt,
  input wire logic                 global_irq_enable,
  input wire logic                 flash_self_store,
  input wire logic                 ready_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic       ctl_wr;
  logic [2:0] arm_age_q;
  // Control writes are the cause of every start and of the read and program stalls; page-load stalls come from data writes.
  assign ctl_wr = io_req.wr && (io_req.addr == nvc_pkg::NVC_OFS_CONTROL);
  // Age of the last arming write; it saturates so a stale arm never looks fresh.
  always_ff @(posedge core_clk) begin
    if (sys_rst) arm_age_q <= 3'h7;
    else if (ctl_wr && io_req.wdata[2]) arm_age_q <= 3'h0;
    else if (arm_age_q != 3'h7) arm_age_q <= arm_age_q + 3'h1;
  end
  sequence s_go_ok;
    ctl_wr && io_req.wdata[1] && !flash_self_store && arm_age_q <= 3'h3;
  endsequence
  sequence s_halt2;
    cpu_halt [*2] ##1 !cpu_halt;
  endsequence
  a_unmapped_zero: assert property (io_req.rd && io_req.addr > 6'h03 |-> io_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_addr_hi_rsvd: assert property (io_req.rd && io_req.addr == 6'h03 |-> io_rdata[7:1] == 7'h00)
    else $error("reserved address bits not zero");
  a_idle_rdata: assert property (!io_req.rd |-> io_rdata == 8'h00)
    else $error("read data without read");
  a_read_stall: assert property (ctl_wr && io_req.wdata == 8'h09 |-> ##1 cpu_halt [*4] ##1 !cpu_halt)
    else $error("read stall not four cycles");
  a_prog_stall: assert property (s_go_ok |-> ##1 s_halt2)
    else $error("program stall not two cycles");
  a_no_arm: assert property (ctl_wr && io_req.wdata[1] && arm_age_q == 3'h7 |=> !cpu_halt)
    else $error("strobe acted without arm");
  a_irq_gate: assert property (ready_irq |-> global_irq_enable && !flash_self_store)
    else $error("ready request while gated");
  a_irq_drop: assert property (s_go_ok |=> !ready_irq)
    else $error("ready request during programming");
endmodule
bind nvc_ctrl nvc_ctrl_monitor u_mon (.core_clk(core_clk), .sys_rst(sys_rst), .io_req(io_req),
  .io_rdata(io_rdata), .cpu_halt(cpu_halt), .global_irq_enable(global_irq_enable),
  .flash_self_store(flash_self_store), .ready_irq(ready_irq));

//--- verification/nvc_cpu_model.sv
// Behavioural CPU core issuing I/O register writes and reads.
`timescale 1ns/100ps
module nvc_cpu_model (
  input  wire logic            core_clk,
  input  wire logic            cpu_halt,
  input  wire logic [7:0]      io_rdata,
  output nvc_pkg::nvc_io_req_s io_req
);
  initial io_req = '0;
  task automatic idle();
    @(posedge core_clk);
    #1;
    while (cpu_halt) begin
      @(posedge core_clk);
      #1;
    end
  endtask
  // Released write data is inverted so stale bytes are never mistaken for fresh ones.
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    idle();
    io_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    #1;
    io_req.wr = 1'b0;
    io_req.wdata = ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    idle();
    io_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk);
    d = io_rdata;
    #1;
    io_req.rd = 1'b0;
  endtask
endmodule

//--- verification/data_eeprom_access_ctrl_tb_top.sv
// Self-checking bench for the data EEPROM access controller.
`timescale 1ns/100ps
module data_eeprom_access_ctrl_tb_top;
  localparam int unsigned EW = 8;
  localparam int unsigned SW = 4;
  logic                 core_clk;
  logic                 sys_rst;
  logic                 gie;
  logic                 fss;
  logic                 cpu_halt;
  logic                 ready_irq;
  logic [7:0]           io_rdata;
  logic [7:0]           v;
  nvc_pkg::nvc_io_req_s io_req;
  int                   err_count;
  int                   checked;
  int                   cyc;
  nvc_ctrl #(.CYC_ERASE_WR(EW), .CYC_SINGLE(SW)) u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .io_req(io_req), .io_rdata(io_rdata), .cpu_halt(cpu_halt), .global_irq_enable(gie),
    .flash_self_store(fss), .ready_irq(ready_irq));
  nvc_cpu_model u_cpu (.core_clk(core_clk), .cpu_halt(cpu_halt), .io_rdata(io_rdata),
    .io_req(io_req));
  // Clock at 20 MHz.
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // A hang ends the run as a mismatch.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [5:0] a, input logic [7:0] exp);
    u_cpu.rd(a, v);
    chk(v, exp);
  endtask
  // Arm then strobe, the only sanctioned way to start programming.
  task automatic prog(input logic [7:0] m);
    u_cpu.wr(6'h00, 8'h0c | m);
    u_cpu.wr(6'h00, 8'h0e | m);
  endtask
  // Counts cycles until the ready request returns, which marks the end of programming.
  task automatic wt(input int n);
    int k;
    k = 0;
    while (!ready_irq && k < 40) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    chk(8'(k), 8'(n));
  endtask
  task automatic t_mode(input logic [1:0] m, input logic [7:0] d, input int n, input logic [7:0] e);
    u_cpu.wr(6'h01, d);
    prog({2'b00, m, 4'h0});
    wt(n);
    rc(6'h00, {2'b00, m, 4'h8});
    u_cpu.wr(6'h00, 8'h09);
    rc(6'h01, e);
  endtask
  initial begin
    sys_rst = 1'b1;
    gie = 1'b1;
    fss = 1'b0;
    repeat (20) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    rc(6'h01, 8'h00);
    u_cpu.wr(6'h03, 8'hff);
    rc(6'h03, 8'h01);
    rc(6'h05, 8'h00);
    u_cpu.wr(6'h02, 8'ha5);
    u_cpu.wr(6'h01, 8'h3c);
    prog(8'h00);
    rc(6'h00, 8'h8e);
    u_cpu.wr(6'h00, 8'h78);
    repeat (12) @(posedge core_clk);
    rc(6'h00, 8'h08);
    chk({7'h00, ready_irq}, 8'h01);
    gie = 1'b0;
    #1 chk({7'h00, ready_irq}, 8'h00);
    gie = 1'b1;
    fss = 1'b1;
    #1 chk({7'h00, ready_irq}, 8'h00);
    prog(8'h00);
    rc(6'h00, 8'h0c);
    fss = 1'b0;
    u_cpu.wr(6'h03, 8'h00);
    t_mode(2'h0, 8'h0f, EW, 8'h0f);
    t_mode(2'h1, 8'h5a, SW, 8'hff);
    t_mode(2'h2, 8'h5a, SW, 8'h5a);
    u_cpu.wr(6'h03, 8'h01);
    u_cpu.wr(6'h00, 8'h09);
    rc(6'h01, 8'h3c);
    u_cpu.wr(6'h03, 8'h00);
    u_cpu.wr(6'h00, 8'h48);
    u_cpu.wr(6'h02, 8'h04);
    u_cpu.wr(6'h01, 8'hf0);
    u_cpu.wr(6'h02, 8'h05);
    u_cpu.wr(6'h01, 8'haa);
    u_cpu.wr(6'h01, 8'h55);
    prog(8'h00);
    wt(EW);
    rc(6'h00, 8'h08);
    u_cpu.wr(6'h00, 8'h09);
    rc(6'h01, 8'h00);
    u_cpu.wr(6'h02, 8'h04);
    u_cpu.wr(6'h00, 8'h09);
    rc(6'h01, 8'hf0);
    u_cpu.wr(6'h00, 8'h48);
    prog(8'h30);
    wt(1);
    rc(6'h00, 8'h3c);
    u_cpu.wr(6'h00, 8'h0a);
    rc(6'h00, 8'h08);
    u_cpu.wr(6'h00, 8'h0c);
    repeat (6) @(posedge core_clk);
    u_cpu.wr(6'h00, 8'h0a);
    rc(6'h00, 8'h08);
    prog(8'h10);
    repeat (2) @(posedge core_clk);
    #1 sys_rst = 1'b1;
    @(posedge core_clk);
    #1 sys_rst = 1'b0;
    rc(6'h00, 8'h10);
    @(posedge core_clk);
    #1 sys_rst = 1'b1;
    @(posedge core_clk);
    #1 sys_rst = 1'b0;
    rc(6'h00, 8'h00);
    stop_test();
  end
endmodule
